// ---- core/gcr_map.svh ----
// Register map constants for the global control register bank
`ifndef GCR_MAP_SVH
`define GCR_MAP_SVH
`define GCR_BASE_ADDR 25'h010_8000
`define GCR_BASE_MASK 25'h1FF_F000
`define GCR_OFS_CLKCFG 12'h000
`define GCR_OFS_SRST 12'h008
`define GCR_OFS_ID 12'h00C
`define GCR_OFS_ISTAT 12'h010
`define GCR_OFS_IMASK 12'h014
`define GCR_BIT_CORE_FREQ 14
`define GCR_BIT_REF_HI 13
`define GCR_BIT_REF_LO 12
`define GCR_BIT_RCLK_DIS 8
`define GCR_BIT_SRST 18
`define GCR_BIT_IRQ 24
`define GCR_ID_DEV_HI 15
`define GCR_ID_DEV_LO 4
`define GCR_ID_REV_HI 3
`define GCR_ID_REV_LO 0
`define GCR_RST_BIT 1'b0
`define GCR_RST_CODE 2'h0
`define GCR_RST_WORD 32'h0000_0000
`define GCR_RST_HALF 16'h0000
`endif

// ---- core/gcr_pkg.sv ----
// Types for the global control register bank
package gcr_pkg;
   typedef enum logic [1:0] {
      GCR_REF_38M88_BYPASS,
      GCR_REF_19M44,
      GCR_REF_10M00,
      GCR_REF_77M76
   } gcr_ref_freq_t;

   typedef struct packed {
      logic core_clock_freq_select;
      gcr_ref_freq_t ref_input_freq_code;
      logic recovery_master_clock_disable;
      logic packet_core_soft_reset;
      logic packet_core_irq_mask;
      logic irq_sync1;
      logic irq_sync2;
   } gcr_ctl_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic rvalid;
      logic [15:0] hi_latch;
   } gcr_rd_t;
endpackage : gcr_pkg

// ---- core/gcr_bus_if.sv ----
// Internal carrier for word reads between the bank and its read mux
`timescale 1ns/100ps
interface gcr_bus_if;
   logic [11:0] ofs;
   logic [31:0] word;
   logic hit;
   modport bank (output ofs, input word, input hit);
   modport mux (input ofs, output word, output hit);
endinterface : gcr_bus_if

// ---- core/gcr_read_mux.sv ----
// Combinational word read mux of the global register bank
`timescale 1ns/100ps
`include "gcr_map.svh"
module gcr_read_mux (
   gcr_bus_if.mux rd, // Offset in, word out
   input wire gcr_pkg::gcr_ctl_t ctl, // Control state
   input wire logic irq_status, // Synced core interrupt
   input wire logic [11:0] dev_code, // Boundary-scan device code low bits
   input wire logic [3:0] rev_code // Boundary-scan revision
);
   always_comb begin
      rd.word = `GCR_RST_WORD;
      rd.hit = 1'b1;
      case (rd.ofs)
         `GCR_OFS_CLKCFG: begin
            rd.word[`GCR_BIT_CORE_FREQ] = ctl.core_clock_freq_select;
            rd.word[`GCR_BIT_REF_HI:`GCR_BIT_REF_LO] =
               ctl.ref_input_freq_code;
            rd.word[`GCR_BIT_RCLK_DIS] = ctl.recovery_master_clock_disable;
         end
         `GCR_OFS_SRST: begin
            rd.word[`GCR_BIT_SRST] = ctl.packet_core_soft_reset;
         end
         `GCR_OFS_ID: begin
            rd.word[`GCR_ID_DEV_HI:`GCR_ID_DEV_LO] = dev_code;
            rd.word[`GCR_ID_REV_HI:`GCR_ID_REV_LO] = rev_code;
         end
         `GCR_OFS_ISTAT: begin
            rd.word[`GCR_BIT_IRQ] = irq_status;
         end
         `GCR_OFS_IMASK: begin
            rd.word[`GCR_BIT_IRQ] = ctl.packet_core_irq_mask;
         end
         default: begin
            rd.hit = 1'b0;
         end
      endcase
   end
endmodule : gcr_read_mux

// ---- core/gcr_top.sv ----
// Global control register bank: clock config, soft reset, id, irq gate
`timescale 1ns/100ps
`include "gcr_map.svh"
module gcr_top (
   ref_clk, // 20 MHz register bus clock
   reset, // Async active-high device reset
   clk_en, // Freezes all state while low
   addr, // Byte address of the access
   wdata, // Write data, low 16 used in 16-bit mode
   wr_en, // Write strobe, one cycle
   rd_en, // Read strobe, one cycle
   bus_width_select_pin, // High 32-bit, low 16-bit access
   system_clock_rate_pin, // High when 25 MHz system clock applied
   core_irq_req, // Packet core interrupt request, async
   dev_code, // Boundary-scan device code low 12 bits
   rev_code, // Boundary-scan revision bits
   rdata, // Read data
   rvalid, // Read data valid, one cycle
   core_clk_75m_sel, // Core clock 75 MHz when high
   ref_freq_code, // Reference input frequency code
   recovery_clk_run, // Recovery master clock enable
   packet_core_reset, // Holds packet core in reset
   irq_out // Device interrupt output, active high
);
   input wire logic ref_clk;
   input wire logic reset;
   input wire logic clk_en;
   input wire logic [24:0] addr;
   input wire logic [31:0] wdata;
   input wire logic wr_en;
   input wire logic rd_en;
   input wire logic bus_width_select_pin;
   input wire logic system_clock_rate_pin;
   input wire logic core_irq_req;
   input wire logic [11:0] dev_code;
   input wire logic [3:0] rev_code;
   output logic [31:0] rdata;
   output logic rvalid;
   output logic core_clk_75m_sel;
   output logic [1:0] ref_freq_code;
   output logic recovery_clk_run;
   output logic packet_core_reset;
   output logic irq_out;

   typedef struct packed {
      gcr_pkg::gcr_ctl_t ctl;
      gcr_pkg::gcr_rd_t rd;
      logic [15:0] wr_hi;
      logic core_clk_75m_sel;
      logic recovery_clk_run;
      logic irq_out;
   } gcr_state_t;

   gcr_state_t state_q;
   gcr_state_t state_d;
   gcr_bus_if rdbus ();

   logic bank_hit;
   logic [11:0] word_ofs;
   logic half_low;
   logic [31:0] wword;
   logic wr_commit;

   assign bank_hit = (addr & `GCR_BASE_MASK) == `GCR_BASE_ADDR;
   // halves: offset+0 is upper half, offset+2 lower, big-endian
   assign word_ofs = {addr[11:2], 2'b00};
   assign half_low = addr[1];
   assign rdbus.ofs = word_ofs;

   gcr_read_mux u_read_mux (
      .rd(rdbus.mux),
      .ctl(state_q.ctl),
      .irq_status(state_q.ctl.irq_sync2),
      .dev_code(dev_code),
      .rev_code(rev_code)
   );

   always_comb begin
      state_d = state_q;
      wword = wdata;
      wr_commit = 1'b0;
      state_d.rd.rvalid = 1'b0;
      // Two-flop sync of the core request
      state_d.ctl.irq_sync1 = core_irq_req;
      state_d.ctl.irq_sync2 = state_q.ctl.irq_sync1;
      if (wr_en && bank_hit) begin
         if (bus_width_select_pin) begin
            wr_commit = 1'b1;
         end else if (!half_low) begin
            // upper half held until lower half written
            state_d.wr_hi = wdata[15:0];
         end else begin
            wword = {state_q.wr_hi, wdata[15:0]};
            wr_commit = 1'b1;
         end
      end
      if (wr_commit) begin
         case (word_ofs)
            `GCR_OFS_CLKCFG: begin
               state_d.ctl.core_clock_freq_select =
                  wword[`GCR_BIT_CORE_FREQ];
               state_d.ctl.ref_input_freq_code = gcr_pkg::gcr_ref_freq_t'(
                  wword[`GCR_BIT_REF_HI:`GCR_BIT_REF_LO]);
               state_d.ctl.recovery_master_clock_disable =
                  wword[`GCR_BIT_RCLK_DIS];
            end
            `GCR_OFS_SRST: begin
               state_d.ctl.packet_core_soft_reset = wword[`GCR_BIT_SRST];
            end
            `GCR_OFS_IMASK: begin
               state_d.ctl.packet_core_irq_mask = wword[`GCR_BIT_IRQ];
            end
            default: begin
               // id, status and unmapped writes dropped
               state_d.wr_hi = state_q.wr_hi;
            end
         endcase
      end
      if (rd_en && bank_hit) begin
         state_d.rd.rvalid = 1'b1;
         if (bus_width_select_pin) begin
            state_d.rd.rdata = rdbus.word;
         end else if (!half_low) begin
            // upper half first; lower half copied to hi_latch, which the lower-half read does not use
            state_d.rd.rdata = {`GCR_RST_HALF, rdbus.word[31:16]};
            state_d.rd.hi_latch = rdbus.word[15:0];
         end else begin
            state_d.rd.rdata = {`GCR_RST_HALF, rdbus.word[15:0]};
         end
      end
      // rate pin low forces 50 MHz path
      state_d.core_clk_75m_sel = system_clock_rate_pin &
         state_d.ctl.core_clock_freq_select;
      state_d.recovery_clk_run = ~state_d.ctl.recovery_master_clock_disable;
      // masked output, fed only by the second sync flop
      state_d.irq_out = state_q.ctl.irq_sync2 &
         state_d.ctl.packet_core_irq_mask;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q.ctl.core_clock_freq_select <= `GCR_RST_BIT;
         state_q.ctl.ref_input_freq_code <= gcr_pkg::GCR_REF_38M88_BYPASS;
         state_q.ctl.recovery_master_clock_disable <= `GCR_RST_BIT;
         state_q.ctl.packet_core_soft_reset <= `GCR_RST_BIT;
         state_q.ctl.packet_core_irq_mask <= `GCR_RST_BIT;
         state_q.ctl.irq_sync1 <= `GCR_RST_BIT;
         state_q.ctl.irq_sync2 <= `GCR_RST_BIT;
         state_q.rd.rdata <= `GCR_RST_WORD;
         state_q.rd.rvalid <= `GCR_RST_BIT;
         state_q.rd.hi_latch <= `GCR_RST_HALF;
         state_q.wr_hi <= `GCR_RST_HALF;
         state_q.core_clk_75m_sel <= `GCR_RST_BIT;
         state_q.recovery_clk_run <= 1'b1;
         state_q.irq_out <= `GCR_RST_BIT;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   assign rdata = state_q.rd.rdata;
   assign rvalid = state_q.rd.rvalid;
   assign core_clk_75m_sel = state_q.core_clk_75m_sel;
   assign ref_freq_code = state_q.ctl.ref_input_freq_code;
   assign recovery_clk_run = state_q.recovery_clk_run;
   // core held in reset while bit set
   assign packet_core_reset = state_q.ctl.packet_core_soft_reset;
   assign irq_out = state_q.irq_out;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_irq_out_gate: assert property (
      clk_en |=> irq_out == ($past(state_q.ctl.irq_sync2) &&
         state_q.ctl.packet_core_irq_mask))
      else $error("irq output does not follow status and mask");
   a_irq_status_sync: assert property (
      clk_en ##1 clk_en |=> state_q.ctl.irq_sync2 == $past(core_irq_req, 2))
      else $error("status bit not two cycles behind request");
   a_mask_write: assert property (
      clk_en && wr_en && bank_hit && bus_width_select_pin &&
      word_ofs == `GCR_OFS_IMASK |=>
      state_q.ctl.packet_core_irq_mask == $past(wdata[`GCR_BIT_IRQ]))
      else $error("mask write not stored");
   a_soft_reset_out: assert property (
      clk_en && wr_en && bank_hit && bus_width_select_pin &&
      word_ofs == `GCR_OFS_SRST |=>
      packet_core_reset == $past(wdata[`GCR_BIT_SRST]))
      else $error("core reset does not follow bit");
   a_core_clk_sel: assert property (
      !system_clock_rate_pin && clk_en |=> !core_clk_75m_sel)
      else $error("75 MHz selected with rate pin low");
   a_rclk_gate: assert property (
      clk_en && wr_en && bank_hit && bus_width_select_pin &&
      word_ofs == `GCR_OFS_CLKCFG |=>
      recovery_clk_run == !$past(wdata[`GCR_BIT_RCLK_DIS]))
      else $error("recovery clock gate wrong sense");
   a_id_upper_zero: assert property (
      rvalid && $past(word_ofs) == `GCR_OFS_ID && $past(bus_width_select_pin)
      |-> rdata[31:16] == `GCR_RST_HALF)
      else $error("identification upper bits not zero");
   a_id_mirror: assert property (
      clk_en && rd_en && bank_hit && bus_width_select_pin &&
      word_ofs == `GCR_OFS_ID |=>
      rdata[`GCR_ID_DEV_HI:`GCR_ID_DEV_LO] == $past(dev_code) &&
      rdata[`GCR_ID_REV_HI:`GCR_ID_REV_LO] == $past(rev_code))
      else $error("identification does not mirror scan codes");
   a_unmapped_read: assert property (
      clk_en && rd_en && !bank_hit |=> !rvalid)
      else $error("read outside bank answered");
   a_unmapped_zero: assert property (
      clk_en && rd_en && bank_hit && !rdbus.hit |=>
      rdata == `GCR_RST_WORD)
      else $error("unmapped offset read not zero");
   a_ro_write_ignored: assert property (
      clk_en && wr_en && word_ofs == `GCR_OFS_ISTAT |=>
      $stable(state_q.ctl.packet_core_irq_mask))
      else $error("status write changed mask");

   c_irq_fires: cover property (irq_out);
   c_core_reset: cover property (packet_core_reset);
   c_half_write: cover property (wr_en && bank_hit && !bus_width_select_pin);
   c_id_read: cover property (rd_en && word_ofs == `GCR_OFS_ID);
endmodule : gcr_top

// ---- bench/gcr_host_model.sv ----
// Host processor model driving single-cycle strobes on the register bus
`timescale 1ns/100ps
module gcr_host_model (
   input wire logic ref_clk, // Bus clock
   output logic [24:0] addr, // Byte address
   output logic [31:0] wdata, // Write data
   output logic wr_en, // Write strobe
   output logic rd_en, // Read strobe
   input wire logic [31:0] rdata, // Read data
   input wire logic rvalid // Read data valid
);
   initial begin
      addr = 25'h000_0000;
      wdata = 32'h0000_0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end

   // whole word or half per strobe
   task automatic wr(input logic [24:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      // Released bus shows no stale value
      wdata <= ~d;
      addr <= ~a;
   endtask : wr

   task automatic rd(input logic [24:0] a, output logic [31:0] d,
                     output logic ok);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      addr <= ~a;
      // Valid stands only until the next edge
      #1;
      ok = rvalid;
      d = rdata;
   endtask : rd
endmodule : gcr_host_model

// ---- bench/global_control_registers_tb.sv ----
// Self-checking bench for the global control register bank
`timescale 1ns/100ps
module global_control_registers_tb;
   localparam logic [24:0] BASE = 25'h010_8000;
   logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, width = 1'b1;
   logic rate = 1'b0, irq_req = 1'b0, wr_en, rd_en, rvalid;
   logic [24:0] addr;
   logic [31:0] wdata, rdata;
   logic [11:0] dev = 12'h000;
   logic [3:0] rev = 4'h0;
   logic c75, run, crst, irq_out;
   logic [1:0] ref_code;
   logic [31:0] cfg, srs, msk, d;
   logic irq, ok;
   logic [11:0] offs [6] = '{12'h000, 12'h008, 12'h00C, 12'h010,
                             12'h014, 12'h004};
   int n_mismatch = 0, n_tests = 0;

   always #25 ref_clk = ~ref_clk;

   gcr_top i_gcr_top (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .bus_width_select_pin(width), .system_clock_rate_pin(rate),
      .core_irq_req(irq_req), .dev_code(dev), .rev_code(rev),
      .rdata(rdata), .rvalid(rvalid), .core_clk_75m_sel(c75),
      .ref_freq_code(ref_code), .recovery_clk_run(run),
      .packet_core_reset(crst), .irq_out(irq_out));

   gcr_host_model i_gcr_host_model (.ref_clk(ref_clk), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .rvalid(rvalid));

   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask : chk

   function automatic logic [31:0] word(logic [11:0] o);
      case (o)
         12'h000: return cfg;
         12'h008: return srs;
         12'h00C: return {16'h0000, dev, rev};
         12'h010: return {7'h00, irq, 24'h00_0000};
         12'h014: return msk;
         default: return 32'h0000_0000;
      endcase
   endfunction : word

   // host sends zero in unused bits of writable words
   task automatic put(logic [11:0] o, logic [31:0] v);
      if (o == 12'h000) cfg = v & 32'h0000_7100;
      if (o == 12'h008) srs = v & 32'h0004_0000;
      if (o == 12'h014) msk = v & 32'h0100_0000;
      if (o == 12'h000 || o == 12'h008 || o == 12'h014) v = word(o);
      i_gcr_host_model.wr(BASE | 25'(o), v);
   endtask : put

   task automatic rchk(logic [11:0] o);
      i_gcr_host_model.rd(BASE | 25'(o), d, ok);
      chk("rvalid", 32'h1, {31'h0, ok});
      chk("rdata", word(o), d);
   endtask : rchk

   task automatic ochk();
      repeat (2) @(posedge ref_clk);
      #1;
      chk("outputs", {cfg[14] & rate, cfg[13:12], ~cfg[8], srs[18],
         irq & msk[24]}, {c75, ref_code, run, crst, irq_out});
   endtask : ochk

   task automatic rstchk();
      cfg = 0;
      srs = 0;
      msk = 0;
      ochk();
      foreach (offs[k]) rchk(offs[k]);
   endtask : rstchk

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   initial begin
      repeat (4000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      void'($urandom(66669));
      {dev, rev} = 16'($urandom);
      irq = 1'b0;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      rstchk();
      for (int i = 0; i < 32; i++) begin
         d = $urandom;
         d[13:12] = 2'(i >> 1);
         rate <= 1'($urandom);
         // no recovered port clock in use
         put(offs[i[0] ? $urandom_range(1, 5) : 0], d);
         ochk();
         foreach (offs[k]) rchk(offs[k]);
      end
      // Strobes outside the bank and while frozen change nothing
      i_gcr_host_model.wr(25'h000_0000, 32'h0000_7100);
      i_gcr_host_model.wr(25'h010_9000, 32'h0000_7100);
      clk_en <= 1'b0;
      i_gcr_host_model.wr(BASE, 32'h0000_7100);
      clk_en <= 1'b1;
      i_gcr_host_model.rd(25'h010_9000, d, ok);
      chk("rvalid", 32'h0, {31'h0, ok});
      rchk(12'h000);
      for (int i = 0; i < 4; i++) begin
         irq_req <= i[0];
         irq = i[0];
         put(12'h014, {7'h00, i[1], 24'h00_0000});
         ochk();
         rchk(12'h010);
      end
      width <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         d = $urandom & (i ? 32'h0100_0000 : 32'h0000_7100);
         if (i) msk = d;
         else cfg = d;
         i_gcr_host_model.wr(BASE | 25'(i * 20), {16'h0000, d[31:16]});
         i_gcr_host_model.wr(BASE | 25'(i * 20 + 2), {16'h0000, d[15:0]});
         i_gcr_host_model.rd(BASE | 25'(i * 20), d, ok);
         chk("hi half", word(12'(i * 20)) >> 16,
            {16'h0000, d[15:0]});
         i_gcr_host_model.rd(BASE | 25'(i * 20 + 2), d, ok);
         chk("lo half", word(12'(i * 20)) & 32'h0000_FFFF,
            {16'h0000, d[15:0]});
      end
      width <= 1'b1;
      put(12'h008, 32'h0004_0000);
      ochk();
      reset <= 1'b1;
      @(posedge ref_clk);
      reset <= 1'b0;
      rstchk();
      final_report();
   end
endmodule : global_control_registers_tb
